// ===== hw/zcdl_pkg.sv
// Notes on behaviour
// - one level event output follows inverted detector; accepts no events
// - configured edge of the detector output sets the cross flag
// - interrupt request while edge mode is not none, cross flag and event mask bit 0 set, or while toggle log and mask bit 1 set
// - edge mode: 0 none, 1 rising, 2 falling, 3 both
// - edge detection uses the output after inversion
// - idle sleep behaves exactly like active mode
// - standby disables the block unless standby run bit 7 is set
// - power-down disables event, pin output, pin enable and new flags; a pending interrupt stays
// - output pin enable bit 6 routes the output to the pin
// - invert bit 3 inverts output for state, event, pin and interrupt
// - block works only with enable bit 0 set; control resets to zero
// - status bit 4 shows output level after three-cycle synchroniser
// - writing one to status bit 0 clears cross flag; zero does nothing
// - without inversion the state bit is one while input above reference
package zcdl_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam int unsigned ZCDL_AW              = 8;
   localparam int unsigned ZCDL_DW              = 8;
   localparam logic [7:0]  ZCDL_OFS_CTRL        = 8'h00;
   localparam logic [7:0]  ZCDL_OFS_EDGE        = 8'h02;
   localparam logic [7:0]  ZCDL_OFS_STATUS      = 8'h03;
   localparam logic [7:0]  ZCDL_OFS_EVLOG       = 8'h04;
   localparam logic [7:0]  ZCDL_OFS_EVMASK      = 8'h05;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int unsigned ZCDL_CTRL_ENABLE     = 0;
   localparam int unsigned ZCDL_CTRL_INVERT     = 3;
   localparam int unsigned ZCDL_CTRL_OUT_PIN_EN = 6;
   localparam int unsigned ZCDL_CTRL_STDBY_RUN  = 7;
   localparam int unsigned ZCDL_STAT_CROSS      = 0;
   localparam int unsigned ZCDL_STAT_STATE      = 4;
   localparam int unsigned ZCDL_EV_CROSS        = 0;
   localparam int unsigned ZCDL_EV_TOGGLE       = 1;

   // writable bits of the control register
   localparam logic [7:0]  ZCDL_CTRL_WMASK      = 8'hc9;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [7:0]  ZCDL_CTRL_RST        = 8'h00;
   localparam logic [1:0]  ZCDL_MODE_RST        = 2'h0;
   localparam logic [1:0]  ZCDL_EVMASK_RST      = 2'h1;

   // ------------------------------------------------------------------
   // edge modes and sleep modes
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      ZCDL_EDGE_NONE    = 2'b00,
      ZCDL_EDGE_RISING  = 2'b01,
      ZCDL_EDGE_FALLING = 2'b10,
      ZCDL_EDGE_BOTH    = 2'b11
   } zcdl_edge_type;

   typedef enum logic [1:0] {
      ZCDL_SLP_ACTIVE   = 2'b00,
      ZCDL_SLP_IDLE     = 2'b01,
      ZCDL_SLP_STANDBY  = 2'b10,
      ZCDL_SLP_PWRDOWN  = 2'b11
   } zcdl_sleep_type;

endpackage : zcdl_pkg

// ===== hw/zcdl_core.sv
// Chosen here: strobed register access.
`timescale 1ns/100ps
module zcdl_core (
   input  wire logic                          clk,
   input  wire logic                          arst_n,
   input  wire logic                          ce,
   input  wire logic [zcdl_pkg::ZCDL_AW-1:0]  addr,
   input  wire logic [zcdl_pkg::ZCDL_DW-1:0]  wdata,
   input  wire logic                          wr,
   input  wire logic                          rd,
   output logic      [zcdl_pkg::ZCDL_DW-1:0]  rdata,
   input  wire logic                          detector_input_pin,
   input  wire zcdl_pkg::zcdl_sleep_type      sleep_mode,
   output logic                               event_out,
   output logic                               out_pin_o,
   output logic                               out_pin_oe,
   output logic                               irq
);
   import zcdl_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]    ctrl_r;
      zcdl_edge_type edge_mode_r;
      logic [1:0]    evmask_r;
      logic          cross_flag_r;
      logic [1:0]    evlog_r;
      logic          sync1_r;
      logic          sync2_r;
      logic          sync3_r;
      logic          level_r;
      logic          seen_r;
      logic          state_r;
      logic [7:0]    rdata_r;
      logic          irq_r;
   } zcdl_state_type;

   zcdl_state_type st_r;
   zcdl_state_type st_nxt;

   logic           active;
   logic           det_out;
   logic           cur_lvl;
   logic           rise;
   logic           fall;
   logic           hit;
   logic           rd_evlog;
   logic [7:0]     status_val;

   // ------------------------------------------------------------------
   // asynchronous paths
   // ------------------------------------------------------------------
   // idle counts as active; standby only with the run bit; power-down
   // always off regardless of configuration
   always_comb begin
      unique case (sleep_mode)
         ZCDL_SLP_ACTIVE:  active = st_r.ctrl_r[ZCDL_CTRL_ENABLE];
         ZCDL_SLP_IDLE:    active = st_r.ctrl_r[ZCDL_CTRL_ENABLE];
         ZCDL_SLP_STANDBY: active = st_r.ctrl_r[ZCDL_CTRL_ENABLE]
                                 & st_r.ctrl_r[ZCDL_CTRL_STDBY_RUN];
         ZCDL_SLP_PWRDOWN: active = 1'b0;
      endcase
   end

   // the event and the pin must follow the comparator with no clock,
   // so they stay combinational; they run even while the clock is off
   assign det_out    = detector_input_pin
                       ^ st_r.ctrl_r[ZCDL_CTRL_INVERT];
   assign event_out  = active & det_out;
   assign out_pin_o  = active & det_out;
   assign out_pin_oe = active & st_r.ctrl_r[ZCDL_CTRL_OUT_PIN_EN];

   // ------------------------------------------------------------------
   // edge detection
   // ------------------------------------------------------------------
   // compare against the last level seen while clocked: a crossing that
   // happened while the clock stood still is still caught on restart
   assign cur_lvl = st_r.level_r ^ st_r.ctrl_r[ZCDL_CTRL_INVERT];
   assign rise    = cur_lvl & ~st_r.seen_r;
   assign fall    = ~cur_lvl & st_r.seen_r;

   always_comb begin
      unique case (st_r.edge_mode_r)
         ZCDL_EDGE_NONE:    hit = 1'b0;
         ZCDL_EDGE_RISING:  hit = rise;
         ZCDL_EDGE_FALLING: hit = fall;
         ZCDL_EDGE_BOTH:    hit = rise | fall;
      endcase
   end

   assign rd_evlog = rd && (addr == ZCDL_OFS_EVLOG);

   always_comb begin
      status_val                  = 8'h00;
      status_val[ZCDL_STAT_CROSS] = st_r.cross_flag_r;
      status_val[ZCDL_STAT_STATE] = st_r.state_r;
   end

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;

      // three flops; a change counts once the second and third agree
      st_nxt.sync1_r = detector_input_pin;
      st_nxt.sync2_r = st_r.sync1_r;
      st_nxt.sync3_r = st_r.sync2_r;
      if (st_r.sync2_r == st_r.sync3_r) begin
         st_nxt.level_r = st_r.sync3_r;
      end
      st_nxt.state_r = cur_lvl;

      // tracking follows the level even while disabled, so enabling
      // the block never produces a false edge
      st_nxt.seen_r = cur_lvl;

      // register writes
      if (wr) begin
         unique case (addr)
            ZCDL_OFS_CTRL: begin
               st_nxt.ctrl_r = wdata & ZCDL_CTRL_WMASK;
            end
            ZCDL_OFS_EDGE: begin
               st_nxt.edge_mode_r = zcdl_edge_type'(wdata[1:0]);
            end
            ZCDL_OFS_STATUS: begin
               if (wdata[ZCDL_STAT_CROSS]) begin
                  st_nxt.cross_flag_r = 1'b0;
               end
            end
            ZCDL_OFS_EVMASK: begin
               st_nxt.evmask_r = wdata[1:0];
            end
            default: begin
            end
         endcase
      end

      // read-clear of the event log, before the sets below
      if (rd_evlog) begin
         st_nxt.evlog_r = 2'h0;
      end

      // hardware sets override a clear in the same cycle
      if (active && hit) begin
         st_nxt.cross_flag_r                = 1'b1;
         st_nxt.evlog_r[ZCDL_EV_CROSS]      = 1'b1;
      end
      if (active && (rise || fall)) begin
         st_nxt.evlog_r[ZCDL_EV_TOGGLE]     = 1'b1;
      end

      // read data, one cycle after the strobe; unmapped reads zero
      st_nxt.rdata_r = 8'h00;
      if (rd) begin
         unique case (addr)
            ZCDL_OFS_CTRL:    st_nxt.rdata_r = st_r.ctrl_r;
            ZCDL_OFS_EDGE:    st_nxt.rdata_r = {6'h00, st_r.edge_mode_r};
            ZCDL_OFS_STATUS:  st_nxt.rdata_r = status_val;
            ZCDL_OFS_EVLOG:   st_nxt.rdata_r = {6'h00, st_r.evlog_r};
            ZCDL_OFS_EVMASK:  st_nxt.rdata_r = {6'h00, st_r.evmask_r};
            default:          st_nxt.rdata_r = 8'h00;
         endcase
      end

      // the request holds until software clears the flag or reads the event log, or changes the mask or the edge mode
      st_nxt.irq_r = ((st_nxt.edge_mode_r != ZCDL_EDGE_NONE)
                      & st_nxt.cross_flag_r
                      & st_nxt.evmask_r[ZCDL_EV_CROSS])
                   | (st_nxt.evlog_r[ZCDL_EV_TOGGLE]
                      & st_nxt.evmask_r[ZCDL_EV_TOGGLE]);
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r             <= '0;
         st_r.ctrl_r      <= ZCDL_CTRL_RST;
         st_r.edge_mode_r <= zcdl_edge_type'(ZCDL_MODE_RST);
         st_r.evmask_r    <= ZCDL_EVMASK_RST;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign rdata = st_r.rdata_r;
   assign irq   = st_r.irq_r;

endmodule : zcdl_core

// ===== tb/zcdl_chk.sv
`timescale 1ns/100ps
module zcdl_chk (
   input wire logic                         clk,
   input wire logic                         arst_n,
   input wire logic                         ce,
   input wire logic [zcdl_pkg::ZCDL_AW-1:0] addr,
   input wire logic [zcdl_pkg::ZCDL_DW-1:0] wdata,
   input wire logic                         wr,
   input wire logic                         rd,
   input wire logic [zcdl_pkg::ZCDL_DW-1:0] rdata,
   input wire logic                         detector_input_pin,
   input wire zcdl_pkg::zcdl_sleep_type     sleep_mode,
   input wire logic                         event_out,
   input wire logic                         out_pin_o,
   input wire logic                         out_pin_oe,
   input wire logic                         irq
);
   import zcdl_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [7:0] ctl_s;
   logic       act_s;
   // control shadow kept from bus writes, since the checker sees only ports
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl_s <= ZCDL_CTRL_RST;
      end else if (ce && wr && (addr == ZCDL_OFS_CTRL)) begin
         ctl_s <= wdata & ZCDL_CTRL_WMASK;
      end
   end
   assign act_s = ctl_s[ZCDL_CTRL_ENABLE]
      && ((sleep_mode == ZCDL_SLP_ACTIVE) || (sleep_mode == ZCDL_SLP_IDLE)
      || ((sleep_mode == ZCDL_SLP_STANDBY) && ctl_s[ZCDL_CTRL_STDBY_RUN]));
   // ------------------------------------------------------------------
   // port relations
   // ------------------------------------------------------------------
   a_pin_same: assert property (out_pin_o == (act_s
      && (detector_input_pin ^ ctl_s[ZCDL_CTRL_INVERT])))
      else $error("pin data differs from model");
   a_event_model: assert property (event_out == (act_s
      && (detector_input_pin ^ ctl_s[ZCDL_CTRL_INVERT])))
      else $error("event level differs from model");
   a_oe_model: assert property (out_pin_oe == (act_s
      && ctl_s[ZCDL_CTRL_OUT_PIN_EN]))
      else $error("pin enable differs from model");
   a_pwrdown_off: assert property (sleep_mode == ZCDL_SLP_PWRDOWN |->
      !event_out && !out_pin_oe) else $error("output alive in power-down");
   a_oe_cause: assert property ($changed(out_pin_oe) |->
      $past(wr) || $changed(sleep_mode)) else $error("pin enable moved");
   a_event_cause: assert property ($changed(event_out) |->
      $past(wr) || $changed(sleep_mode) || $changed(detector_input_pin))
      else $error("event moved without cause");
   a_irq_hold: assert property ($fell(irq) |-> $past(wr) || $past(rd))
      else $error("irq dropped without software");
   // stable input for 8 cycles is past the detector latency, so no new flag
   a_no_edge_irq: assert property ((ce && !wr && $stable(detector_input_pin)
      && $stable(sleep_mode))[*8] |-> ##1 !$rose(irq))
      else $error("irq rose without an edge");
   a_read_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside answer cycle");
   a_ce_freeze: assert property (!ce |=> $stable(irq))
      else $error("irq moved with clock stopped");
   c_irq_rise: cover property ($rose(irq));
   c_irq_fall: cover property ($fell(irq));
   c_standby: cover property (sleep_mode == ZCDL_SLP_STANDBY && event_out);
endmodule : zcdl_chk

bind zcdl_core zcdl_chk u_zcdl_chk (.clk(clk), .arst_n(arst_n), .ce(ce),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .detector_input_pin(detector_input_pin), .sleep_mode(sleep_mode),
   .event_out(event_out), .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe),
   .irq(irq));

// ===== tb/zcdl_afe.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// comparator front end, settles off the clock edge like a real crossing
// ------------------------------------------------------------------
module zcdl_afe (
   input  wire logic above_ref,
   output logic      detector_input_pin
);
   initial detector_input_pin = 1'b0;
   always @(above_ref) detector_input_pin <= #3 above_ref;
endmodule : zcdl_afe

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import zcdl_pkg::*;
   // ------------------------------------------------------------------
   // stimulus, model and checks
   // ------------------------------------------------------------------
   logic           clk = 1'b0;
   logic           arst_n = 1'b0;
   logic           ce = 1'b1;
   logic [7:0]     addr = 8'h00;
   logic [7:0]     wdata = 8'h00;
   logic           wr = 1'b0;
   logic           rd = 1'b0;
   logic           above_ref = 1'b0;
   zcdl_sleep_type sleep_mode = ZCDL_SLP_ACTIVE;
   logic [7:0]     rdata;
   logic           det, ev, pin_o, pin_oe, irq;
   logic [7:0]     ctl = 8'h00;
   logic [1:0]     mode = 2'h0;
   logic [1:0]     slp = 2'h0;
   bit             flag = 1'b0;
   int             bad_count = 0;
   int             num_checks = 0;
   int             seed = 32'h460cf33d;
   always #4 clk = ~clk;
   zcdl_afe u_zcdl_afe (.above_ref(above_ref), .detector_input_pin(det));
   zcdl_core u_zcdl_core (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .detector_input_pin(det), .sleep_mode(sleep_mode), .event_out(ev),
      .out_pin_o(pin_o), .out_pin_oe(pin_oe), .irq(irq));
   function automatic bit lvl();
      return above_ref ^ ctl[3];
   endfunction : lvl
   function automatic bit act();
      return ctl[0] && (slp < 2 || (slp == 2 && ctl[7]));
   endfunction : act
   task automatic conclude();
      if (bad_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   task automatic check_rd(input logic [7:0] exp);
      num_checks++;
      if (rdata !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t read data %h", $time, rdata);
      end
   endtask : check_rd
   task automatic check_pin(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t pin level", $time);
      end
   endtask : check_pin
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      if (a == ZCDL_OFS_CTRL) ctl = d & ZCDL_CTRL_WMASK;
      if (a == ZCDL_OFS_EDGE) mode = d[1:0];
      if (a == ZCDL_OFS_STATUS && d[0]) flag = 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 check_rd(exp);
   endtask : rreg
   // config edges (an invert change) settle before the flag is cleared
   task automatic cfg(input logic [7:0] c, input logic [7:0] m);
      wreg(ZCDL_OFS_CTRL, c);
      wreg(ZCDL_OFS_EDGE, m);
      repeat (8) @(posedge clk);
      wreg(ZCDL_OFS_STATUS, 8'h01);
   endtask : cfg
   task automatic step();
      bit o;
      o = lvl();
      @(posedge clk);
      above_ref <= ~above_ref;
      #1 if (act() && o != lvl() && (mode == 3 || mode == {o, ~o})) flag = 1;
      repeat (8) @(posedge clk);
      #1 check_pin(ev, act() && lvl());
      check_pin(pin_o, act() && lvl());
      check_pin(pin_oe, act() && ctl[6]);
      check_pin(irq, mode != 0 && flag);
   endtask : step
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      rreg(8'h00, 8'h00);
      rreg(8'h02, 8'h00);
      rreg(8'h03, 8'h00);
      rreg(8'h01, 8'h00);
      rreg(ZCDL_OFS_EVMASK, 8'h01);
      rreg(ZCDL_OFS_EVLOG, 8'h00);
      wreg(ZCDL_OFS_CTRL, 8'hff);
      rreg(ZCDL_OFS_CTRL, ctl);
      for (int i = 0; i < 8; i++) begin
         cfg({($random(seed) & 1) == 1, 3'h0, i > 3, 3'h1}, 8'(i % 4));
         for (int j = 0; j < 2; j++) begin
            step();
            rreg(ZCDL_OFS_STATUS, {3'h0, lvl(), 3'h0, flag});
         end
         wreg(ZCDL_OFS_STATUS, 8'h00);
         rreg(ZCDL_OFS_STATUS, {3'h0, lvl(), 3'h0, flag});
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         sleep_mode <= zcdl_sleep_type'(2'(i % 4));
         slp = 2'(i % 4);
         cfg(8'h41 | (8'($random(seed)) & 8'h88), 8'h03);
         step();
         step();
      end
      @(posedge clk);
      sleep_mode <= ZCDL_SLP_ACTIVE;
      slp = 2'h0;
      cfg(8'h01, 8'h03);
      @(posedge clk);
      ce <= 1'b0;
      above_ref <= ~above_ref;
      repeat (6) @(posedge clk);
      ce <= 1'b1;
      flag = 1'b1;
      repeat (8) @(posedge clk);
      rreg(ZCDL_OFS_STATUS, {3'h0, lvl(), 3'h0, flag});
      rreg(ZCDL_OFS_EVLOG, 8'h03);
      rreg(ZCDL_OFS_EVLOG, 8'h00);
      // cross flag stays set but masked; only the toggle log may raise irq
      wreg(ZCDL_OFS_EVMASK, 8'h02);
      #1 check_pin(irq, 1'b0);
      rreg(ZCDL_OFS_EVMASK, 8'h02);
      @(posedge clk);
      above_ref <= ~above_ref;
      repeat (8) @(posedge clk);
      #1 check_pin(irq, 1'b1);
      rreg(ZCDL_OFS_EVLOG, 8'h03);
      conclude();
   end
   initial begin
      #400000;
      bad_count++;
      conclude();
   end
endmodule : tb_top
